/* hdl/eipc_ctrl.sv */
/*
 external request priority controller: six request lines, enables,
 sense selects, priority registers, and core request outputs.
 assumes a single-cycle register port and level on-chip requests.
*/
// Behaviour
// - per-line enable bit, zero at reset
// - level low or falling edge sets flag
// - read one then write zero clears flag
// - level mode: service with pin high clears
// - edge mode: service clears flag at any pin level
// - writes only clear flags, reset zero
// - priority bit: 0 low, 1 high
// - priority bits map to source groups
`timescale 1ns/1ps
module eipc_ctrl (
   // clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // register port
   input wire eipc_pkg::eipc_bus_req_type busReq,
   output logic [7:0] busRdata,
   // external request pins, active low
   input wire logic [eipc_pkg::NumLines-1:0] extRequestPinN,
   // on-chip sources
   input wire logic [eipc_pkg::NumOnChip-1:0] chipSrcReq,
   // exception handling acknowledge per line
   input wire logic [eipc_pkg::NumLines-1:0] lineServiced,
   // core side
   output eipc_pkg::eipc_core_req_type coreReq,
   output logic coreHighPending,
   output logic coreAnyPending,
   output logic irqOut
);
   logic [7:0] sense_q, sense_d;
   logic [7:0] enable_q, enable_d;
   logic [7:0] prioA_q, prioA_d;
   logic [7:0] prioB_q, prioB_d;
   logic [7:0] rdata_q, rdata_d;
   logic [eipc_pkg::NumLines-1:0] armed_q, armed_d;
   logic [eipc_pkg::NumLines-1:0] flagPrev_q, flagPrev_d;
   logic [eipc_pkg::NumLines-1:0] irqStat_q, irqStat_d;
   logic [eipc_pkg::NumLines-1:0] irqMask_q, irqMask_d;
   logic [eipc_pkg::NumLines-1:0] flags;
   logic [eipc_pkg::NumLines-1:0] swClear;
   logic [eipc_pkg::NumLines-1:0] lineHigh;
   logic [eipc_pkg::NumOnChip-1:0] chipHigh;
   logic [eipc_pkg::NumLines-1:0] lineReq;
   logic wrFlags;

   ////////////////////////////////////////////////////////////////////////
   // request lines
   assign wrFlags = busReq.wr && (busReq.addr == eipc_pkg::OffsFlags);

   always_comb begin
      // a zero written clears only a bit seen as one by an earlier read
      swClear = {eipc_pkg::NumLines{wrFlags}} & armed_q
         & ~busReq.wdata[eipc_pkg::NumLines-1:0];
   end

   generate
      for (genvar i = 0; i < eipc_pkg::NumLines; i++) begin : gLine
         eipc_line uLine (
            .mclk(mclk),
            .nrst(nrst),
            .extRequestPinN(extRequestPinN[i]),
            .extRequestSense(sense_q[i]),
            .swClear(swClear[i]),
            .serviced(lineServiced[i]),
            .extRequestFlag(flags[i])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // register file
   always_comb begin
      sense_d = sense_q;
      enable_d = enable_q;
      prioA_d = prioA_q;
      prioB_d = prioB_q;
      irqMask_d = irqMask_q;
      armed_d = armed_q & flags;
      rdata_d = eipc_pkg::ResetByte;
      if (busReq.wr) begin
         unique case (busReq.addr)
            eipc_pkg::OffsSense:
               sense_d = busReq.wdata & eipc_pkg::LineMask;
            eipc_pkg::OffsEnable:
               enable_d = busReq.wdata & eipc_pkg::LineMask;
            eipc_pkg::OffsPrioA:
               prioA_d = busReq.wdata;
            eipc_pkg::OffsPrioB:
               prioB_d = busReq.wdata & eipc_pkg::PrioBMask;
            eipc_pkg::OffsIrqMask:
               irqMask_d = busReq.wdata[eipc_pkg::NumLines-1:0];
            eipc_pkg::OffsFlags:
               armed_d = armed_q & flags & ~swClear;
            default: ;
         endcase
      end
      if (busReq.rd) begin
         unique case (busReq.addr)
            eipc_pkg::OffsSense: rdata_d = sense_q;
            eipc_pkg::OffsEnable: rdata_d = enable_q;
            eipc_pkg::OffsFlags: begin
               rdata_d = {2'h0, flags};
               armed_d = flags;
            end
            eipc_pkg::OffsPrioA: rdata_d = prioA_q;
            eipc_pkg::OffsPrioB: rdata_d = prioB_q;
            eipc_pkg::OffsIrqStat: rdata_d = {2'h0, irqStat_q};
            eipc_pkg::OffsIrqMask: rdata_d = {2'h0, irqMask_q};
            default: rdata_d = eipc_pkg::ResetByte;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         sense_q <= eipc_pkg::ResetByte;
         enable_q <= eipc_pkg::ResetByte;
         prioA_q <= eipc_pkg::ResetByte;
         prioB_q <= eipc_pkg::ResetByte;
         rdata_q <= eipc_pkg::ResetByte;
         armed_q <= '0;
         irqMask_q <= '0;
      end else begin
         sense_q <= sense_d;
         enable_q <= enable_d;
         prioA_q <= prioA_d;
         prioB_q <= prioB_d;
         rdata_q <= rdata_d;
         armed_q <= armed_d;
         irqMask_q <= irqMask_d;
      end
   end

   assign busRdata = rdata_q;

   ////////////////////////////////////////////////////////////////////////
   // event status: rising flag sets a sticky bit, write one clears it
   always_comb begin
      flagPrev_d = flags;
      irqStat_d = irqStat_q;
      if (busReq.wr && (busReq.addr == eipc_pkg::OffsIrqStat)) begin
         irqStat_d = irqStat_q & ~busReq.wdata[eipc_pkg::NumLines-1:0];
      end
      irqStat_d = irqStat_d | (flags & ~flagPrev_q);
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         flagPrev_q <= '0;
         irqStat_q <= '0;
      end else begin
         flagPrev_q <= flagPrev_d;
         irqStat_q <= irqStat_d;
      end
   end

   assign irqOut = |(irqStat_q & irqMask_q);

   ////////////////////////////////////////////////////////////////////////
   // priority mapping
   always_comb begin
      lineHigh = '0;
      lineHigh[0] = prioA_q[eipc_pkg::PaReq0];
      lineHigh[1] = prioA_q[eipc_pkg::PaReq1];
      lineHigh[2] = prioA_q[eipc_pkg::PaReq23];
      lineHigh[3] = prioA_q[eipc_pkg::PaReq23];
      lineHigh[4] = prioA_q[eipc_pkg::PaReq45];
      lineHigh[5] = prioA_q[eipc_pkg::PaReq45];
      chipHigh = '0;
      chipHigh[eipc_pkg::SrcWatchdog] = prioA_q[eipc_pkg::PaWatchdog];
      chipHigh[eipc_pkg::SrcTimer0] = prioA_q[eipc_pkg::PaTimer0];
      chipHigh[eipc_pkg::SrcTimer1] = prioA_q[eipc_pkg::PaTimer1];
      chipHigh[eipc_pkg::SrcTimer2] = prioA_q[eipc_pkg::PaTimer2];
      chipHigh[eipc_pkg::SrcTimer3] = prioB_q[eipc_pkg::PbTimer3];
      chipHigh[eipc_pkg::SrcTimer4] = prioB_q[eipc_pkg::PbTimer4];
      chipHigh[eipc_pkg::SrcDma] = prioB_q[eipc_pkg::PbDma];
      chipHigh[eipc_pkg::SrcSerial0] = prioB_q[eipc_pkg::PbSerial0];
      chipHigh[eipc_pkg::SrcSerial1] = prioB_q[eipc_pkg::PbSerial1];
      chipHigh[eipc_pkg::SrcConverter] = prioB_q[eipc_pkg::PbConverter];
   end

   ////////////////////////////////////////////////////////////////////////
   // core requests; sources beyond the converter are level 0 only
   assign lineReq = flags & enable_q[eipc_pkg::NumLines-1:0];
   // one driver for the whole bundle keeps the struct a single net
   assign coreReq = '{lineReq: lineReq, lineHigh: lineHigh,
      chipReq: chipSrcReq, chipHigh: chipHigh};
   assign coreHighPending = |(lineReq & lineHigh)
      | |(chipSrcReq & chipHigh);
   assign coreAnyPending = |lineReq | |chipSrcReq;
endmodule : eipc_ctrl

/* hdl/eipc_pkg.sv */
/*
 package for the external request priority controller: register map,
 field layout, reset values and the source index map.
 assumes an 8-bit register port with byte offsets.
*/
package eipc_pkg;
   localparam int NumLines = 6;
   localparam int NumOnChip = 13;
   localparam logic [7:0] OffsSense = 8'hf4;
   localparam logic [7:0] OffsEnable = 8'hf5;
   localparam logic [7:0] OffsFlags = 8'hf6;
   localparam logic [7:0] OffsPrioA = 8'hf7;
   localparam logic [7:0] OffsPrioB = 8'hf8;
   localparam logic [7:0] OffsIrqStat = 8'hf9;
   localparam logic [7:0] OffsIrqMask = 8'hfa;
   localparam logic [7:0] ResetByte = 8'h00;
   localparam logic [7:0] LineMask = 8'h3f;
   localparam logic [7:0] PrioBMask = 8'hee;
   // on-chip source indices
   localparam int SrcWatchdog = 0;
   localparam int SrcTimer0 = 1;
   localparam int SrcTimer1 = 2;
   localparam int SrcTimer2 = 3;
   localparam int SrcTimer3 = 4;
   localparam int SrcTimer4 = 5;
   localparam int SrcDma = 6;
   localparam int SrcSerial0 = 7;
   localparam int SrcSerial1 = 8;
   localparam int SrcConverter = 9;
   // priority a bit positions
   localparam int PaReq0 = 7;
   localparam int PaReq1 = 6;
   localparam int PaReq23 = 5;
   localparam int PaReq45 = 4;
   localparam int PaWatchdog = 3;
   localparam int PaTimer0 = 2;
   localparam int PaTimer1 = 1;
   localparam int PaTimer2 = 0;
   // priority b bit positions
   localparam int PbTimer3 = 7;
   localparam int PbTimer4 = 6;
   localparam int PbDma = 5;
   localparam int PbSerial0 = 3;
   localparam int PbSerial1 = 2;
   localparam int PbConverter = 1;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } eipc_bus_req_type;

   typedef struct packed {
      logic [NumLines-1:0] lineReq;
      logic [NumLines-1:0] lineHigh;
      logic [NumOnChip-1:0] chipReq;
      logic [NumOnChip-1:0] chipHigh;
   } eipc_core_req_type;
endpackage : eipc_pkg

/* hdl/eipc_line.sv */
/*
 one external request line: pin synchroniser, sense and flag.
 assumes the pin is asynchronous to mclk and the owner gives clear pulses.
*/
`timescale 1ns/1ps
module eipc_line (
   // clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // pin and control
   input wire logic extRequestPinN,
   input wire logic extRequestSense,
   input wire logic swClear,
   input wire logic serviced,
   // state
   output logic extRequestFlag
);
   logic [2:0] sync_q, sync_d;
   logic level_q, level_d;
   logic flag_q, flag_d;
   logic setEvt;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      sync_d = {sync_q[1:0], extRequestPinN};
      // a change counts only once stages two and three agree
      level_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : level_q;
      setEvt = extRequestSense ? (level_q & ~level_d) : ~level_d;
      flag_d = flag_q;
      if (swClear) begin
         flag_d = 1'b0;
      end
      if (serviced && (extRequestSense || level_q)) begin
         flag_d = 1'b0;
      end
      // set wins over any clear in the same cycle
      if (setEvt) begin
         flag_d = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         sync_q <= 3'h7;
         level_q <= 1'b1;
         flag_q <= 1'b0;
      end else begin
         sync_q <= sync_d;
         level_q <= level_d;
         flag_q <= flag_d;
      end
   end

   assign extRequestFlag = flag_q;
endmodule : eipc_line

/* verification/eipc_ctrl_assertions.sv */
/*
 checker on the ports of the request priority controller.
 assumes a bind to eipc_ctrl, one clock, reset nrst.
*/
`timescale 1ns/1ps
module eipc_ctrl_assertions (
   // clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // register port
   input wire eipc_pkg::eipc_bus_req_type busReq,
   input wire logic [7:0] busRdata,
   // pins and sources
   input wire logic [5:0] extRequestPinN,
   input wire logic [12:0] chipSrcReq,
   input wire logic [5:0] lineServiced,
   // core side
   input wire eipc_pkg::eipc_core_req_type coreReq,
   input wire logic coreHighPending,
   input wire logic coreAnyPending,
   input wire logic irqOut
);
   // shadow of enable, sense and last write data
   logic [23:0] shadow_q, shadow_d;
   logic [7:0] w;
   assign w = shadow_q[23:16];
   always_comb begin
      shadow_d = {busReq.wdata, shadow_q[15:0]};
      if (busReq.wr && busReq.addr == 8'hf5) shadow_d[7:0] = busReq.wdata;
      if (busReq.wr && busReq.addr == 8'hf4) shadow_d[15:8] = busReq.wdata;
      if (!nrst) shadow_d = 24'h000000;
   end
   always_ff @(posedge mclk) begin
      shadow_q <= shadow_d;
   end
   default clocking dc @(posedge mclk); endclocking
   default disable iff (!nrst);
   gate_enable_a: assert property (
      (coreReq.lineReq & ~shadow_q[5:0]) == 6'h00) else $error("gate");
   level_set_a: assert property (
      (!extRequestPinN[0] && shadow_q[0] && !shadow_q[8])[*8]
      |-> coreReq.lineReq[0]) else $error("level set");
   level_clear_a: assert property (
      extRequestPinN[0][*6] ##0 (lineServiced[0] && !shadow_q[8])
      |=> !coreReq.lineReq[0]) else $error("level clear");
   edge_clear_a: assert property (
      lineServiced[1] && shadow_q[9] |=> !coreReq.lineReq[1])
      else $error("edge clear");
   prio_a_map_a: assert property (
      busReq.wr && busReq.addr == 8'hf7 |=> coreReq.chipHigh[3:0] ==
      {w[0], w[1], w[2], w[3]} && coreReq.lineHigh ==
      {w[4], w[4], w[5], w[5], w[6], w[7]}) else $error("prio a");
   prio_b_map_a: assert property (
      busReq.wr && busReq.addr == 8'hf8 |=> coreReq.chipHigh[12:4] ==
      {3'b000, w[1], w[2], w[3], w[5], w[6], w[7]}) else $error("prio b");
   high_pend_a: assert property (
      coreHighPending == (|(coreReq.lineReq & coreReq.lineHigh) ||
      |(coreReq.chipReq & coreReq.chipHigh))) else $error("high pending");
   any_pend_a: assert property (
      coreReq.chipReq == chipSrcReq && coreAnyPending ==
      (|coreReq.lineReq || |chipSrcReq)) else $error("any pending");
   cover property (coreHighPending);
   cover property (lineServiced[1]);
   cover property (irqOut);
endmodule : eipc_ctrl_assertions

bind eipc_ctrl eipc_ctrl_assertions eipcChk (.mclk(mclk), .nrst(nrst),
   .busReq(busReq), .busRdata(busRdata), .extRequestPinN(extRequestPinN),
   .chipSrcReq(chipSrcReq), .lineServiced(lineServiced),
   .coreReq(coreReq), .coreHighPending(coreHighPending),
   .coreAnyPending(coreAnyPending), .irqOut(irqOut));

/* verification/eipc_far_model.sv */
/*
 far side: request pins and a core that services pending lines.
 assumes the bench raises svcGo to let the core take one request.
*/
`timescale 1ns/1ps
module eipc_far_model (
   // clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // bench commands
   input wire logic [5:0] pinLow,
   input wire logic svcGo,
   // controller side
   input wire eipc_pkg::eipc_core_req_type coreReq,
   output logic [5:0] extRequestPinN,
   output logic [5:0] lineServiced
);
   logic [5:0] cand, pick;
   assign extRequestPinN = ~pinLow;
   always_comb begin
      cand = coreReq.lineReq & coreReq.lineHigh;
      // level 1 first, then lowest line
      if (cand == 6'h00) cand = coreReq.lineReq;
      pick = cand & (~cand + 6'h01);
   end
   // one pulse per grant, a gap between pulses
   always_ff @(posedge mclk) begin
      if (!nrst || !svcGo || lineServiced != 6'h00) lineServiced <= 6'h00;
      else lineServiced <= pick;
   end
endmodule : eipc_far_model

/* verification/tb.sv */
/*
 bench for the request priority controller.
 assumes a 40 MHz mclk and the far model on pins and core side.
*/
`timescale 1ns/1ps
module tb;
   logic mclk, nrst, svcGo, coreHighPending, coreAnyPending, irqOut;
   eipc_pkg::eipc_bus_req_type busReq;
   eipc_pkg::eipc_core_req_type coreReq;
   logic [7:0] busRdata, req;
   logic [5:0] pinLow, pinN, svc;
   logic [12:0] chipSrcReq;
   int errCount, nTests;
   assign req = {2'b00, coreReq.lineReq};
   eipc_ctrl dut (.mclk(mclk), .nrst(nrst), .busReq(busReq),
      .busRdata(busRdata), .extRequestPinN(pinN), .chipSrcReq(chipSrcReq),
      .lineServiced(svc), .coreReq(coreReq), .irqOut(irqOut),
      .coreHighPending(coreHighPending), .coreAnyPending(coreAnyPending));
   eipc_far_model far (.mclk(mclk), .nrst(nrst), .pinLow(pinLow),
      .svcGo(svcGo), .coreReq(coreReq), .extRequestPinN(pinN),
      .lineServiced(svc));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [7:0] s, e);
      nTests++;
      if (s !== e) begin
         errCount++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : cyc
   task automatic wr(input logic [7:0] a, d);
      @(posedge mclk);
      busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk);
      busReq.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, e);
      @(posedge mclk);
      busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge mclk);
      busReq.rd <= 1'b0;
      #1 chk("read", busRdata, e);
   endtask : rd
   task automatic serve;
      svcGo <= 1'b1;
      cyc(1);
      svcGo <= 1'b0;
      cyc(3);
   endtask : serve
   task automatic levelLine;
      pinLow <= 6'h01;
      cyc(8);
      chk("masked", req, 8'h00);
      wr(8'hf5, 8'h01);
      cyc(1);
      chk("level", req, 8'h01);
      rd(8'hf6, 8'h01);
      wr(8'hf6, 8'h00);
      cyc(2);
      chk("set wins", req, 8'h01);
      pinLow <= 6'h00;
      cyc(8);
      chk("kept", req, 8'h01);
      serve;
      chk("served", req, 8'h00);
   endtask : levelLine
   task automatic edgeLine;
      wr(8'hf4, 8'h02);
      wr(8'hf5, 8'h02);
      wr(8'hfa, 8'h02);
      pinLow <= 6'h02;
      cyc(8);
      chk("edge", {req[7:1], irqOut}, 8'h03);
      wr(8'hf6, 8'h3f);
      cyc(2);
      chk("one kept", req, 8'h02);
      rd(8'hf6, 8'h02);
      wr(8'hf6, 8'h00);
      wr(8'hf9, 8'h02);
      cyc(2);
      chk("cleared", {req[7:1], irqOut}, 8'h00);
      pinLow <= 6'h00;
      cyc(6);
      pinLow <= 6'h02;
      cyc(8);
      wr(8'hfa, 8'h00);
      cyc(1);
      chk("masked irq", {req[7:1], irqOut}, 8'h02);
      serve;
      chk("edge served", req, 8'h00);
      pinLow <= 6'h00;
   endtask : edgeLine
   task automatic prioMap;
      wr(8'hf7, 8'h80);
      rd(8'hf7, 8'h80);
      wr(8'hf8, 8'hff);
      rd(8'hf8, 8'hee);
      wr(8'hf8, 8'h20);
      chipSrcReq <= 13'h0040;
      cyc(2);
      chk("line high", {2'b00, coreReq.lineHigh}, 8'h01);
      chk("dma high", {coreHighPending, coreAnyPending}, 8'h03);
      wr(8'hf8, 8'h00);
      cyc(1);
      chk("dma low", {coreHighPending, coreAnyPending}, 8'h01);
      chipSrcReq <= 13'h0000;
   endtask : prioMap
   task automatic endSim;
      $display("errors %0d checks %0d", errCount, nTests);
      if (errCount == 0 && nTests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : endSim
   ////////////////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // run needs some 110 cycles
   initial begin
      #75000;
      errCount++;
      endSim;
   end
   initial begin
      nrst = 1'b0;
      busReq = '0;
      pinLow = 6'h00;
      svcGo = 1'b0;
      chipSrcReq = 13'h0000;
      errCount = 0;
      nTests = 0;
      repeat (2) @(posedge mclk);
      nrst <= 1'b1;
      for (int a = 244; a < 252; a++) rd(8'(a), 8'h00);
      levelLine;
      edgeLine;
      prioMap;
      endSim;
   end
endmodule : tb
